// ---- bmu_bit_modify.sv ----
`timescale 1ns/1ps

module bmu_bit_modify
(
    input  wire bmu_pkg::bmu_op_t                  i_op,
    input  wire logic [bmu_pkg::BMU_BYTE_W-1:0]    i_data,
    input  wire logic [bmu_pkg::BMU_IDX_W-1:0]     i_idx,
    output logic      [bmu_pkg::BMU_BYTE_W-1:0]    o_data,
    output logic                                   o_bit,
    output logic                                   o_modifies
);

    logic [bmu_pkg::BMU_BYTE_W-1:0] mask;

    always_comb
    begin
        mask       = bmu_pkg::BMU_BYTE_W'(1) << i_idx;
        o_bit      = i_data[i_idx];
        o_data     = i_data;
        o_modifies = 1'b0;
        case (i_op)
            bmu_pkg::bit_force_one_op:
            begin
                o_data     = i_data | mask;   // [RULE1]
                o_modifies = 1'b1;
            end
            bmu_pkg::bit_force_zero_op:
            begin
                o_data     = i_data & ~mask;  // [RULE2]
                o_modifies = 1'b1;
            end
            bmu_pkg::bit_invert_op:
            begin
                o_data     = i_data ^ mask;   // [RULE3]
                o_modifies = 1'b1;
            end
            default:
            begin
                o_data     = i_data;
                o_modifies = 1'b0;
            end
        endcase
    end

endmodule

// ---- bmu_bit_unit.sv ----
`timescale 1ns/1ps

//Contract
//RULE1: Setting forces the chosen bit of the byte operand to one and keeps the other seven bits.
//RULE2: Clearing forces the chosen bit of the byte operand to zero and keeps the other bits.
//RULE3: Inverting replaces the chosen bit of the byte operand with its complement and keeps the other bits.
//RULE4: Probing loads the zero flag with the complement of the chosen bit and leaves the operand alone.
//RULE5: Set, clear, invert and probe take the bit index from a 3-bit immediate or the low three bits of a register.
//RULE6: Carry-and writes carry with carry AND the chosen bit.
//RULE7: Carry-and-inverted writes carry with carry AND the complement of the chosen bit.
//RULE8: Carry-or writes carry with carry OR the chosen bit.
//RULE9: Carry-or-inverted writes carry with carry OR the complement of the chosen bit.
//RULE10: Carry-xor writes carry with carry XOR the chosen bit.
//RULE11: Carry-xor-inverted writes carry with carry XOR the complement of the chosen bit.
//RULE12: The carry-combining operations take their bit index only from the 3-bit immediate, never a register.
//RULE13: A memory operand of set, clear or invert is read, changed in the chosen bit only, and written back whole.
//RULE14: Each operation changes no condition flag besides the one it is defined to update.
module bmu_bit_unit
(
    input  wire logic                               i_clk,
    input  wire logic                               i_sys_rst,
    input  wire logic                               i_req_valid,
    input  wire bmu_pkg::bmu_req_t                  i_req,
    output logic                                    o_req_ready,
    output logic                                    o_done,
    output bmu_pkg::bmu_res_t                       o_res,
    output logic                                    o_mem_req,
    output logic                                    o_mem_we,
    output logic      [bmu_pkg::BMU_ADDR_W-1:0]     o_mem_addr,
    output logic      [bmu_pkg::BMU_BYTE_W-1:0]     o_mem_wdata,
    input  wire logic                               i_mem_ack,
    input  wire logic [bmu_pkg::BMU_BYTE_W-1:0]     i_mem_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // types and helpers

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } bmu_state_t;

    // bit index from immediate or low bits of the index register
    function automatic logic [bmu_pkg::BMU_IDX_W-1:0] sel_index(input bmu_pkg::bmu_req_t req);
        if (req.idx_from_reg)
        begin
            sel_index = req.idx_reg[bmu_pkg::BMU_IDX_W-1:0];  // [RULE5]
        end
        else
        begin
            sel_index = req.imm_idx;                          // [RULE5] [RULE12]
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    bmu_state_t                        state_reg;
    bmu_state_t                        state_next;
    bmu_pkg::bmu_req_t                 req_reg;
    bmu_pkg::bmu_req_t                 req_next;
    bmu_pkg::bmu_res_t                 res_reg;
    bmu_pkg::bmu_res_t                 res_next;
    logic                              done_reg;
    logic                              done_next;
    logic                              mem_req_reg;
    logic                              mem_req_next;
    logic                              mem_we_reg;
    logic                              mem_we_next;
    logic [bmu_pkg::BMU_ADDR_W-1:0]    mem_addr_reg;
    logic [bmu_pkg::BMU_ADDR_W-1:0]    mem_addr_next;
    logic [bmu_pkg::BMU_BYTE_W-1:0]    mem_wdata_reg;
    logic [bmu_pkg::BMU_BYTE_W-1:0]    mem_wdata_next;

    ////////////////////////////////////////////////////////////////////////////
    // operand selection and compute

    bmu_pkg::bmu_req_t                 cur_req;
    logic [bmu_pkg::BMU_BYTE_W-1:0]    cur_byte;
    logic [bmu_pkg::BMU_IDX_W-1:0]     cur_idx;
    logic [bmu_pkg::BMU_BYTE_W-1:0]    new_byte;
    logic                              sel_bit;
    logic                              modifies;
    logic                              flag_c;
    logic                              flag_c_we;
    logic                              flag_z;
    logic                              flag_z_we;
    logic                              carry_op;
    logic                              bad_index;
    bmu_pkg::bmu_res_t                 calc_res;

    always_comb
    begin
        // idle works on the incoming request, read phase on the latched one
        cur_req  = (state_reg == ST_IDLE) ? i_req : req_reg;
        cur_byte = (state_reg == ST_READ) ? i_mem_rdata : cur_req.reg_data;
        cur_idx  = sel_index(cur_req);
    end

    bmu_bit_modify u_modify
    (
        .i_op       (cur_req.op),
        .i_data     (cur_byte),
        .i_idx      (cur_idx),
        .o_data     (new_byte),
        .o_bit      (sel_bit),
        .o_modifies (modifies)
    );

    bmu_flag_logic u_flags
    (
        .i_op       (cur_req.op),
        .i_bit      (sel_bit),
        .i_c        (cur_req.c),
        .i_z        (cur_req.z),
        .o_c        (flag_c),
        .o_c_we     (flag_c_we),
        .o_z        (flag_z),
        .o_z_we     (flag_z_we),
        .o_carry_op (carry_op)
    );

    always_comb
    begin
        // carry ops with a register-sourced index are refused
        bad_index        = carry_op & cur_req.idx_from_reg;        // [RULE12]
        calc_res         = '0;
        calc_res.data    = modifies ? new_byte : cur_byte;         // [RULE4]
        calc_res.reg_we  = modifies & ~cur_req.mem_sel & ~bad_index;
        calc_res.mem_wr  = modifies & cur_req.mem_sel & ~bad_index;
        calc_res.c       = bad_index ? cur_req.c : flag_c;         // [RULE14]
        calc_res.c_we    = flag_c_we & ~bad_index;
        calc_res.z       = flag_z;
        calc_res.z_we    = flag_z_we;
        calc_res.illegal = bad_index;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb
    begin
        state_next     = state_reg;
        req_next       = req_reg;
        res_next       = res_reg;
        done_next      = 1'b0;
        mem_req_next   = mem_req_reg;
        mem_we_next    = mem_we_reg;
        mem_addr_next  = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (i_req_valid)
                begin
                    req_next = i_req;
                    if (i_req.mem_sel && !bad_index)
                    begin
                        // memory byte: fetch first
                        mem_req_next  = 1'b1;
                        mem_we_next   = 1'b0;
                        mem_addr_next = i_req.addr;
                        state_next    = ST_READ;
                    end
                    else
                    begin
                        res_next  = calc_res;
                        done_next = 1'b1;
                    end
                end
            end
            ST_READ:
            begin
                if (i_mem_ack)
                begin
                    res_next = calc_res;
                    if (modifies)
                    begin
                        // write the whole byte back
                        mem_we_next    = 1'b1;                    // [RULE13]
                        mem_wdata_next = new_byte;                // [RULE13]
                        state_next     = ST_WRITE;
                    end
                    else
                    begin
                        // probe and carry ops leave memory untouched
                        mem_req_next = 1'b0;                      // [RULE4]
                        done_next    = 1'b1;
                        state_next   = ST_IDLE;
                    end
                end
            end
            ST_WRITE:
            begin
                if (i_mem_ack)
                begin
                    mem_req_next = 1'b0;
                    mem_we_next  = 1'b0;
                    done_next    = 1'b1;                          // [RULE13]
                    state_next   = ST_IDLE;
                end
            end
            default:
            begin
                state_next   = ST_IDLE;
                mem_req_next = 1'b0;
                mem_we_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg     <= ST_IDLE;
            req_reg       <= '0;
            res_reg       <= '0;
            done_reg      <= 1'b0;
            mem_req_reg   <= 1'b0;
            mem_we_reg    <= 1'b0;
            mem_addr_reg  <= bmu_pkg::BMU_ADDR_RST;
            mem_wdata_reg <= bmu_pkg::BMU_DATA_RST;
        end
        else
        begin
            state_reg     <= state_next;
            req_reg       <= req_next;
            res_reg       <= res_next;
            done_reg      <= done_next;
            mem_req_reg   <= mem_req_next;
            mem_we_reg    <= mem_we_next;
            mem_addr_reg  <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_req_ready = (state_reg == ST_IDLE);
    assign o_done      = done_reg;
    assign o_res       = res_reg;
    assign o_mem_req   = mem_req_reg;
    assign o_mem_we    = mem_we_reg;
    assign o_mem_addr  = mem_addr_reg;
    assign o_mem_wdata = mem_wdata_reg;

endmodule

// ---- bmu_bit_unit_asserts.sv ----
`timescale 1ns/1ps

module bmu_bit_unit_asserts
(
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_req_valid,
    input wire bmu_pkg::bmu_req_t i_req,
    input wire logic              o_req_ready,
    input wire logic              o_done,
    input wire bmu_pkg::bmu_res_t o_res,
    input wire logic              o_mem_req,
    input wire logic              o_mem_we,
    input wire logic [15:0]       o_mem_addr,
    input wire logic [7:0]        o_mem_wdata,
    input wire logic              i_mem_ack,
    input wire logic [7:0]        i_mem_rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic             take;
    logic             cop;
    logic [2:0]       idx;
    logic [3:0]       op_reg;
    logic [3:0]       op_next;
    logic [2:0]       idx_reg;
    logic [2:0]       idx_next;
    assign take = i_req_valid && o_req_ready;
    assign cop  = i_req.op inside {[4'h4:4'h9]};
    assign idx  = i_req.idx_from_reg ? i_req.idx_reg[2:0] : i_req.imm_idx;

    ////////////////////////////////////////////////////////////////////////////
    // captured request for memory phases
    always_comb
    begin
        op_next  = take ? i_req.op : op_reg;
        idx_next = take ? idx : idx_reg;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            op_reg  <= 4'h0;
            idx_reg <= 3'h0;
        end
        else
        begin
            op_reg  <= op_next;
            idx_reg <= idx_next;
        end
    end

    function automatic logic [7:0] f_mod(input logic [3:0] op, input logic [7:0] d, input logic [2:0] i);
        case (op)
            4'h0:    f_mod = d | (8'h01 << i);
            4'h1:    f_mod = d & ~(8'h01 << i);
            4'h2:    f_mod = d ^ (8'h01 << i);
            default: f_mod = d;
        endcase
    endfunction

    function automatic logic f_c(input logic [3:0] op, input logic c, input logic b);
        case (op)
            4'h4:    f_c = c & b;
            4'h5:    f_c = c & ~b;
            4'h6:    f_c = c | b;
            4'h7:    f_c = c | ~b;
            4'h8:    f_c = c ^ b;
            default: f_c = c ^ ~b;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    property p_reg_mod;
        take && !i_req.mem_sel && i_req.op inside {[4'h0:4'h2]} |=> o_done && o_res.reg_we && !o_res.c_we
            && !o_res.z_we && o_res.data == f_mod($past(i_req.op), $past(i_req.reg_data), $past(idx));
    endproperty
    a_reg_mod: assert property (p_reg_mod) else $error("register bit modify wrong");

    property p_reg_probe;
        take && !i_req.mem_sel && i_req.op == 4'h3 |=> o_done && o_res.z_we && !o_res.c_we
            && o_res.z == !$past(i_req.reg_data[idx]) && o_res.data == $past(i_req.reg_data);
    endproperty
    a_reg_probe: assert property (p_reg_probe) else $error("register probe wrong");

    property p_reg_carry;
        take && !i_req.mem_sel && cop && !i_req.idx_from_reg |=> o_done && o_res.c_we && !o_res.z_we
            && !o_res.reg_we && o_res.c == f_c($past(i_req.op), $past(i_req.c), $past(i_req.reg_data[idx]));
    endproperty
    a_reg_carry: assert property (p_reg_carry) else $error("carry combine wrong");

    property p_illegal;
        take && cop && i_req.idx_from_reg |=> o_done && o_res.illegal && !o_res.c_we && !o_res.reg_we
            && !o_mem_req && o_res.c == $past(i_req.c);
    endproperty
    a_illegal: assert property (p_illegal) else $error("register index carry op not refused");

    property p_mem_start;
        take && i_req.mem_sel && !(cop && i_req.idx_from_reg) |=> o_mem_req && !o_mem_we
            && o_mem_addr == $past(i_req.addr) && !o_req_ready;
    endproperty
    a_mem_start: assert property (p_mem_start) else $error("memory read not started");

    property p_mem_hold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we) && !o_req_ready;
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");

    property p_mem_write;
        o_mem_req && !o_mem_we && i_mem_ack && op_reg inside {[4'h0:4'h2]} |=> o_mem_req && o_mem_we
            && o_mem_addr == $past(o_mem_addr) && o_mem_wdata == f_mod(op_reg, $past(i_mem_rdata), idx_reg);
    endproperty
    a_mem_write: assert property (p_mem_write) else $error("memory write back wrong");

    property p_mem_done;
        o_mem_req && o_mem_we && i_mem_ack |=> o_done && !o_mem_req && o_res.mem_wr
            && o_res.data == $past(o_mem_wdata) && !o_res.c_we && !o_res.z_we;
    endproperty
    a_mem_done: assert property (p_mem_done) else $error("memory write completion wrong");

    property p_mem_probe;
        o_mem_req && !o_mem_we && i_mem_ack && op_reg == 4'h3 |=> o_done && !o_mem_req && o_res.z_we
            && o_res.z == !$past(i_mem_rdata[idx_reg]) && !o_res.mem_wr;
    endproperty
    a_mem_probe: assert property (p_mem_probe) else $error("memory probe wrong");
endmodule

bind bmu_bit_unit bmu_bit_unit_asserts u_chk
(
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_req_valid (i_req_valid),
    .i_req       (i_req),
    .o_req_ready (o_req_ready),
    .o_done      (o_done),
    .o_res       (o_res),
    .o_mem_req   (o_mem_req),
    .o_mem_we    (o_mem_we),
    .o_mem_addr  (o_mem_addr),
    .o_mem_wdata (o_mem_wdata),
    .i_mem_ack   (i_mem_ack),
    .i_mem_rdata (i_mem_rdata)
);

// ---- bmu_bit_unit_tb_top.sv ----
`timescale 1ns/1ps

module bmu_bit_unit_tb_top;
    localparam logic [15:0] ADDR = 16'h3C5A;
    logic              i_clk;
    logic              i_sys_rst;
    logic              i_req_valid;
    logic              i_mem_ack;
    logic [7:0]        i_mem_rdata;
    logic              o_req_ready;
    logic              o_done;
    logic              o_mem_req;
    logic              o_mem_we;
    logic [15:0]       o_mem_addr;
    logic [7:0]        o_mem_wdata;
    logic [7:0]        mem_byte;
    logic [15:0]       acc_addr;
    bmu_pkg::bmu_req_t i_req;
    bmu_pkg::bmu_res_t o_res;
    int                fails;
    int                tests_run;
    int                mem_delay;
    int                wr_cnt;
    int                cnt;

    bmu_bit_unit i_dut
    (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_req_valid (i_req_valid),
        .i_req       (i_req),
        .o_req_ready (o_req_ready),
        .o_done      (o_done),
        .o_res       (o_res),
        .o_mem_req   (o_mem_req),
        .o_mem_we    (o_mem_we),
        .o_mem_addr  (o_mem_addr),
        .o_mem_wdata (o_mem_wdata),
        .i_mem_ack   (i_mem_ack),
        .i_mem_rdata (i_mem_rdata)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory side: ack after mem_delay cycles, data line toggles when idle
    always @(negedge i_clk)
    begin
        i_mem_ack   <= 1'b0;
        i_mem_rdata <= ~i_mem_rdata;
        if (o_mem_req && !i_mem_ack)
        begin
            if (cnt >= mem_delay)
            begin
                i_mem_ack <= 1'b1;
                cnt       <= 0;
                acc_addr  <= o_mem_addr;
                if (o_mem_we)
                begin
                    mem_byte <= o_mem_wdata;
                    wr_cnt   <= wr_cnt + 1;
                end
                else
                    i_mem_rdata <= mem_byte;
            end
            else
                cnt <= cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_byte(name, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic run_op(input logic [3:0] op, input logic mem, input logic rsel, input logic [2:0] imm,
                          input logic [7:0] ireg, input logic [7:0] d, input logic c, input logic z);
        int n;
        @(negedge i_clk);
        i_req       = {op, mem, rsel, imm, ireg, d, ADDR, c, z};
        i_req_valid = 1'b1;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 50)
        begin
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        i_req_valid = 1'b0;
        while (o_done !== 1'b1 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        check_bit("done", 1'b1, o_done);
    endtask

    function automatic logic [7:0] mod(input int op, input logic [7:0] d, input int i);
        logic [7:0] m;
        m = 8'h01 << i;
        return (op == 0) ? (d | m) : (op == 1) ? (d & ~m) : (d ^ m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reg_modify;
        logic [7:0] d;
        for (int op = 0; op < 3; op++)
            for (int i = 0; i < 8; i++)
            begin
                d = i[1] ? 8'h5A : 8'hA5;
                run_op(op[3:0], 1'b0, i[0], i[0] ? ~i[2:0] : i[2:0], {5'h1A, i[0] ? i[2:0] : ~i[2:0]}, d, 1'b1, 1'b1);
                check_byte("reg data", mod(op, d, i), o_res.data);
                check_bit("reg_we", 1'b1, o_res.reg_we);
                check_bit("flag writes", 1'b0, o_res.c_we | o_res.z_we);
            end
    endtask

    task automatic t_probe;
        for (int i = 0; i < 8; i++)
        begin
            run_op(4'h3, 1'b0, i[0], i[0] ? ~i[2:0] : i[2:0], {5'h05, i[2:0]}, 8'h5A, 1'b0, 1'(8'h5A >> i));
            check_bit("probe z", 1'(~(8'h5A >> i)), o_res.z);
            check_bit("probe z_we", 1'b1, o_res.z_we);
            check_bit("probe c_we", 1'b0, o_res.c_we);
            check_byte("probe data", 8'h5A, o_res.data);
        end
    endtask

    task automatic t_carry;
        logic e;
        for (int op = 4; op < 10; op++)
            for (int k = 0; k < 4; k++)
            begin
                case (op)
                    4: e = k[0] & k[1];
                    5: e = k[0] & ~k[1];
                    6: e = k[0] | k[1];
                    7: e = k[0] | ~k[1];
                    8: e = k[0] ^ k[1];
                    default: e = k[0] ^ ~k[1];
                endcase
                run_op(op[3:0], 1'b0, 1'b0, 3'h3, 8'hF4, k[1] ? 8'h08 : 8'hF7, k[0], ~e);
                check_bit("carry", e, o_res.c);
                check_bit("carry we", 1'b1, o_res.c_we & ~o_res.z_we & ~o_res.illegal);
            end
    endtask

    task automatic t_illegal;
        int w;
        w = wr_cnt;
        for (int op = 4; op < 10; op++)
        begin
            run_op(op[3:0], op[0], 1'b1, 3'h2, 8'h02, 8'h04, op[1], 1'b0);
            check_bit("illegal", 1'b1, o_res.illegal);
            check_bit("illegal writes", 1'b0, o_res.c_we | o_res.reg_we);
            check_bit("illegal c", op[1], o_res.c);
        end
        check_byte("illegal mem writes", w[7:0], wr_cnt[7:0]);
    endtask

    task automatic t_mem;
        int w;
        for (int op = 0; op < 4; op++)
        begin
            mem_byte  = 8'hA6;
            mem_delay = op;
            w         = wr_cnt;
            run_op(op[3:0], 1'b1, op[0], op[0] ? 3'h0 : op[2:0] + 3'h4, {5'h00, op[2:0] + 3'h4}, 8'h00, 1'b0, 1'b1);
            check_byte("mem addr hi", ADDR[15:8], acc_addr[15:8]);
            check_byte("mem addr lo", ADDR[7:0], acc_addr[7:0]);
            check_bit("ready after mem", 1'b1, o_req_ready);
            if (op < 3)
            begin
                check_byte("mem byte", mod(op, 8'hA6, op + 4), mem_byte);
                check_byte("mem result", mod(op, 8'hA6, op + 4), o_res.data);
                check_bit("mem_wr", 1'b1, o_res.mem_wr);
            end
            else
            begin
                check_bit("mem probe z", 1'b0, o_res.z);
                check_byte("probe mem writes", w[7:0], wr_cnt[7:0]);
            end
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_sys_rst   = 1'b1;
        i_req_valid = 1'b0;
        i_req       = '0;
        i_mem_ack   = 1'b0;
        i_mem_rdata = 8'h00;
        mem_byte    = 8'h00;
        acc_addr    = 16'h0000;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reg_modify();
        t_probe();
        t_carry();
        t_illegal();
        t_mem();
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge i_clk);
        fails++;
        wrap_up();
    end
endmodule

// ---- bmu_flag_logic.sv ----
`timescale 1ns/1ps

module bmu_flag_logic
(
    input  wire bmu_pkg::bmu_op_t i_op,
    input  wire logic             i_bit,
    input  wire logic             i_c,
    input  wire logic             i_z,
    output logic                  o_c,
    output logic                  o_c_we,
    output logic                  o_z,
    output logic                  o_z_we,
    output logic                  o_carry_op
);

    always_comb
    begin
        // flags not named by the operation pass through untouched
        o_c        = i_c;                   // [RULE14]
        o_z        = i_z;                   // [RULE14]
        o_c_we     = 1'b0;
        o_z_we     = 1'b0;
        o_carry_op = 1'b0;
        case (i_op)
            bmu_pkg::bit_probe_op:
            begin
                o_z    = ~i_bit;            // [RULE4]
                o_z_we = 1'b1;
            end
            bmu_pkg::carry_and_bit_op:
            begin
                o_c        = i_c & i_bit;   // [RULE6]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            bmu_pkg::carry_and_inv_bit_op:
            begin
                o_c        = i_c & ~i_bit;  // [RULE7]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            bmu_pkg::carry_or_bit_op:
            begin
                o_c        = i_c | i_bit;   // [RULE8]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            bmu_pkg::carry_or_inv_bit_op:
            begin
                o_c        = i_c | ~i_bit;  // [RULE9]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            bmu_pkg::carry_xor_bit_op:
            begin
                o_c        = i_c ^ i_bit;   // [RULE10]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            bmu_pkg::carry_xor_inv_bit_op:
            begin
                o_c        = i_c ^ ~i_bit;  // [RULE11]
                o_c_we     = 1'b1;
                o_carry_op = 1'b1;
            end
            default:
            begin
                o_c_we     = 1'b0;
                o_z_we     = 1'b0;
            end
        endcase
    end

endmodule

// ---- bmu_pkg.sv ----
package bmu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int BMU_BYTE_W = 8;
    localparam int BMU_IDX_W  = 3;
    localparam int BMU_ADDR_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [BMU_BYTE_W-1:0] BMU_DATA_RST = 8'h00;
    localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_RST = 16'h0000;
    localparam logic                  BMU_FLAG_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // operations
    typedef enum logic [3:0]
    {
        bit_force_one_op     = 4'h0,
        bit_force_zero_op    = 4'h1,
        bit_invert_op        = 4'h2,
        bit_probe_op         = 4'h3,
        carry_and_bit_op     = 4'h4,
        carry_and_inv_bit_op = 4'h5,
        carry_or_bit_op      = 4'h6,
        carry_or_inv_bit_op  = 4'h7,
        carry_xor_bit_op     = 4'h8,
        carry_xor_inv_bit_op = 4'h9
    } bmu_op_t;

    ////////////////////////////////////////////////////////////////////////////
    // request and result carriers
    typedef struct packed
    {
        bmu_op_t               op;
        logic                  mem_sel;
        logic                  idx_from_reg;
        logic [BMU_IDX_W-1:0]  imm_idx;
        logic [BMU_BYTE_W-1:0] idx_reg;
        logic [BMU_BYTE_W-1:0] reg_data;
        logic [BMU_ADDR_W-1:0] addr;
        logic                  c;
        logic                  z;
    } bmu_req_t;

    typedef struct packed
    {
        logic [BMU_BYTE_W-1:0] data;
        logic                  reg_we;
        logic                  mem_wr;
        logic                  c;
        logic                  c_we;
        logic                  z;
        logic                  z_we;
        logic                  illegal;
    } bmu_res_t;

endpackage
